// file: design/scfg_pkg.sv
// Package of field positions, select codes and timing constants for the synthesizer config block.
package scfg_pkg;
    localparam int WORD_W = 24;
    localparam int CNT_W = 5;
    // Destination select codes in the two low bits.
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_REFDIV = 2'h1;
    localparam logic [1:0] SEL_FBDIV = 2'h2;
    localparam logic [1:0] SEL_TEST = 2'h3;
    // Control word fields.
    localparam int CW_PRESC_HI = 23;
    localparam int CW_PRESC_LO = 22;
    localparam int CW_PD_MODE = 21;
    localparam int CW_PD_REQ = 20;
    localparam int CW_CUR2_HI = 19;
    localparam int CW_CUR2_LO = 17;
    localparam int CW_CUR1_HI = 16;
    localparam int CW_CUR1_LO = 14;
    localparam int CW_PWR_HI = 13;
    localparam int CW_PWR_LO = 12;
    localparam int CW_MUTE = 11;
    localparam int CW_GAIN = 10;
    localparam int CW_TRI = 9;
    localparam int CW_POL = 8;
    localparam int CW_MUX_HI = 7;
    localparam int CW_MUX_LO = 5;
    localparam int CW_DRST = 4;
    localparam int CW_CORE_HI = 3;
    localparam int CW_CORE_LO = 2;
    // Feedback divider word fields.
    localparam int FW_HALVSEL = 23;
    localparam int FW_HALVEN = 22;
    localparam int FW_GAIN = 21;
    localparam int FW_MAIN_HI = 20;
    localparam int FW_MAIN_LO = 8;
    localparam int FW_SWAL_HI = 6;
    localparam int FW_SWAL_LO = 2;
    // Reference divider word fields.
    localparam int RW_BAND_HI = 21;
    localparam int RW_BAND_LO = 20;
    localparam int RW_TEST = 19;
    localparam int RW_LOCKP = 18;
    localparam int RW_BKL_HI = 17;
    localparam int RW_BKL_LO = 16;
    localparam int RW_DIV_HI = 15;
    localparam int RW_DIV_LO = 2;
    // Reference edges counted before a synchronous power-down takes effect.
    localparam logic [1:0] SYNC_PD_EDGES = 2'h2;
    localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
    typedef enum logic [1:0] {PD_OFF, PD_WAIT_REF, PD_ON} scfg_pd_t;
endpackage

// file: design/scfg_latches.sv
// Serial word capture, three configuration words and power-down control.
// Contract
// [R1] Shift 24 bits MSB first; load on strobe rise.
// [R2] Two low bits choose destination word.
// [R3] Select 00 updates the control word.
// [R4] Control bits 23..22 select prescaler modulus.
// [R5] Control word field layout as specified.
// [R6] Control bit 21 mode, bit 20 request.
// [R7] Request with mode 0: immediate power-down.
// [R8] Mode 1: power-down on second reference edge.
// [R9] Chip-enable low disables at once.
// [R10] Power-down loads counters, three-states, clears lock.
// [R11] Shifting and latching continue in power-down.
// [R12] Host writes reference, control, then feedback.
// [R13] Control word write powers up bias.
// [R14] Host waits settling before feedback word.
// [R15] Unchanged feedback word resumes prior band.
// [R16] Host avoids feedback change during power-down.
// [R17] Feedback divider word field layout.
// [R18] Reference divider word field layout.
// [R19] Programmed power-down holds until cleared.
// [R20] Pump gain follows latest loaded value.
module scfg_latches
    import scfg_pkg::*;
(
    input wire logic mclk, // System clock, 10 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic serClk, // Serial clock, sampled.
    input wire logic serData, // Serial data.
    input wire logic loadStrobe, // Load strobe, sampled.
    input wire logic chipEnable, // Chip enable, low disables.
    input wire logic refDivOut, // Reference divider output, sampled.
    output logic [1:0] prescalerSelect, // Prescaler modulus.
    output logic [2:0] pumpCurrentTwo, // Current setting two.
    output logic [2:0] pumpCurrentOne, // Current setting one.
    output logic [1:0] outputPowerLevel, // Output power level.
    output logic muteUntilLock, // Mute until lock.
    output logic pumpGainSelect, // Latest pump gain select.
    output logic pumpThreeState, // Pump three-state incl. power-down.
    output logic detectorPolarity, // Detector polarity.
    output logic [2:0] outputMuxSelect, // Output mux select.
    output logic dividerReset, // Counter load state incl. power-down.
    output logic [1:0] coreCurrent, // Core current.
    output logic halvedPrescalerInput, // Divided output feeds prescaler.
    output logic outputHalvingEnable, // Output halving.
    output logic [12:0] mainCount, // Main count.
    output logic [4:0] swallowCount, // Swallow count.
    output logic [1:0] bandClockDivider, // Band clock divider.
    output logic testEnableBit, // Test enable.
    output logic lockPrecision, // Lock precision.
    output logic [1:0] backlashWidth, // Backlash pulse width.
    output logic [13:0] refDivide, // Reference divide ratio.
    output logic biasOn, // Bias circuits powered.
    output logic powerDown, // Any power-down active.
    output logic lockDetectClear, // Clears digital lock detect.
    output logic outputsHighZ, // RF outputs high impedance.
    output logic refBufferOff, // Reference buffer disabled.
    output logic bandSelectStart // Pulse: feedback word loaded.
);
    import scfg_pkg::*;

    typedef struct packed {
        logic [WORD_W-1:0] shift;
        logic clkPrev;
        logic lePrev;
        logic refPrev;
        logic [WORD_W-1:0] ctrl;
        logic [WORD_W-1:0] fb;
        logic [WORD_W-1:0] refWord;
        logic gain;
        logic bias;
        scfg_pd_t pd;
        logic [1:0] refEdges;
        logic bandPulse;
    } scfg_state_t;

    scfg_state_t st_r, st_nxt;
    logic serRise, leRise, refRise, hwOff, pdAny;
    logic [WORD_W-1:0] newWord;

    always_comb begin
        st_nxt = st_r;
        serRise = serClk && !st_r.clkPrev;
        leRise = loadStrobe && !st_r.lePrev;
        refRise = refDivOut && !st_r.refPrev;
        newWord = st_r.shift;
        st_nxt.clkPrev = serClk;
        st_nxt.lePrev = loadStrobe;
        st_nxt.refPrev = refDivOut;
        st_nxt.bandPulse = 1'b0;
        // Shifting runs regardless of power state. [R11]
        if (serRise) begin
            st_nxt.shift = {st_r.shift[WORD_W-2:0], serData}; // [R1]
        end
        // Synchronous power-down counts reference edges after the strobe. [R8]
        if (st_r.pd == PD_WAIT_REF && refRise) begin
            st_nxt.refEdges = st_r.refEdges + 2'h1;
            if (st_r.refEdges + 2'h1 == SYNC_PD_EDGES) begin
                st_nxt.pd = PD_ON;
            end
        end
        if (leRise) begin
            case (newWord[1:0]) // [R2]
                SEL_CONTROL: begin
                    st_nxt.ctrl = newWord; // [R3]
                    st_nxt.gain = newWord[CW_GAIN]; // [R20]
                    st_nxt.bias = 1'b1; // [R13]
                    st_nxt.refEdges = 2'h0;
                    if (!newWord[CW_PD_REQ]) begin // [R6]
                        st_nxt.pd = PD_OFF; // [R19]
                    end else if (!newWord[CW_PD_MODE]) begin
                        st_nxt.pd = PD_ON; // [R7]
                    end else if (st_r.pd != PD_ON) begin
                        st_nxt.pd = PD_WAIT_REF; // [R8]
                    end
                end
                SEL_REFDIV: st_nxt.refWord = newWord; // [R18]
                SEL_FBDIV: begin
                    st_nxt.fb = newWord; // [R17]
                    st_nxt.gain = newWord[FW_GAIN]; // [R20]
                    st_nxt.bandPulse = 1'b1;
                end
                SEL_TEST: ; // Factory word is ignored.
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= '{shift: WORD_RESET, clkPrev: 1'b0, lePrev: 1'b0, refPrev: 1'b0,
                      ctrl: WORD_RESET, fb: WORD_RESET, refWord: WORD_RESET, gain: 1'b0,
                      bias: 1'b0, pd: PD_OFF, refEdges: 2'h0, bandPulse: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Band selection is held in the stored feedback word, so it survives power-down. [R15]
    assign hwOff = !chipEnable; // [R9] [R19]
    assign pdAny = hwOff || st_r.pd == PD_ON || !st_r.bias;
    assign powerDown = pdAny;
    assign biasOn = st_r.bias && !pdAny;
    assign prescalerSelect = st_r.ctrl[CW_PRESC_HI:CW_PRESC_LO]; // [R4]
    assign pumpCurrentTwo = st_r.ctrl[CW_CUR2_HI:CW_CUR2_LO]; // [R5]
    assign pumpCurrentOne = st_r.ctrl[CW_CUR1_HI:CW_CUR1_LO];
    assign outputPowerLevel = st_r.ctrl[CW_PWR_HI:CW_PWR_LO];
    assign muteUntilLock = st_r.ctrl[CW_MUTE];
    assign pumpGainSelect = st_r.gain;
    assign detectorPolarity = st_r.ctrl[CW_POL];
    assign outputMuxSelect = st_r.ctrl[CW_MUX_HI:CW_MUX_LO];
    assign coreCurrent = st_r.ctrl[CW_CORE_HI:CW_CORE_LO];
    // Power-down overrides the programmed three-state and reset bits. [R10]
    assign pumpThreeState = st_r.ctrl[CW_TRI] || pdAny; // [R10]
    assign dividerReset = st_r.ctrl[CW_DRST] || pdAny; // [R10]
    assign lockDetectClear = pdAny; // [R10]
    assign outputsHighZ = pdAny; // [R10]
    assign refBufferOff = pdAny; // [R10]
    assign halvedPrescalerInput = st_r.fb[FW_HALVSEL];
    assign outputHalvingEnable = st_r.fb[FW_HALVEN];
    assign mainCount = st_r.fb[FW_MAIN_HI:FW_MAIN_LO];
    assign swallowCount = st_r.fb[FW_SWAL_HI:FW_SWAL_LO];
    assign bandClockDivider = st_r.refWord[RW_BAND_HI:RW_BAND_LO];
    assign testEnableBit = st_r.refWord[RW_TEST];
    assign lockPrecision = st_r.refWord[RW_LOCKP];
    assign backlashWidth = st_r.refWord[RW_BKL_HI:RW_BKL_LO];
    assign refDivide = st_r.refWord[RW_DIV_HI:RW_DIV_LO];
    assign bandSelectStart = st_r.bandPulse;
endmodule

// file: verification/scfg_latches_asserts.sv
// Port checker for load timing and power-down of the config block.
module scfg_latches_asserts (
    input wire logic mclk, // Clock.
    input wire logic sys_rst, // Reset.
    input wire logic loadStrobe, // Strobe.
    input wire logic chipEnable, // Enable.
    input wire logic refDivOut, // Ref edges.
    input wire logic [12:0] mainCount, // Main count.
    input wire logic [13:0] refDivide, // Ref ratio.
    input wire logic pumpGainSelect, // Gain.
    input wire logic biasOn, // Bias.
    input wire logic powerDown, // Power-down.
    input wire logic outputsHighZ, // Outputs off.
    input wire logic bandSelectStart // Band pulse.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    property p_ce; !chipEnable |-> powerDown; endproperty
    a_ce: assert property (p_ce) else $error("enable low but powered");
    property p_off; powerDown |-> outputsHighZ; endproperty
    a_off: assert property (p_off) else $error("outputs live in power-down");
    property p_bias; biasOn |-> !powerDown; endproperty
    a_bias: assert property (p_bias) else $error("bias on in power-down");
    property p_resume; $fell(powerDown) |-> chipEnable; endproperty
    a_resume: assert property (p_resume) else $error("woke with enable low");
    property p_bss; bandSelectStart |-> $past(loadStrobe) && !$past(loadStrobe, 2); endproperty
    a_bss: assert property (p_bss) else $error("band pulse without load");
    property p_pulse; bandSelectStart |=> !bandSelectStart; endproperty
    a_pulse: assert property (p_pulse) else $error("band pulse too long");
    property p_hold;
        !$past(loadStrobe) || $past(loadStrobe, 2) |->
            $stable(mainCount) && $stable(refDivide) && $stable(pumpGainSelect);
    endproperty
    a_hold: assert property (p_hold) else $error("word moved without load");
    property p_rise;
        $rose(powerDown) && chipEnable |-> ($past(loadStrobe) && !$past(loadStrobe, 2))
            || ($past(refDivOut) && !$past(refDivOut, 2));
    endproperty
    a_rise: assert property (p_rise) else $error("power-down without cause");
endmodule
bind scfg_latches scfg_latches_asserts u_scfg_latches_asserts (.*);

// file: verification/scfg_host.sv
// Host model that shifts words into the config block over the serial link.
module scfg_host (
    input wire logic mclk, // System clock.
    output logic serClk = 1'b0, // Serial clock, low between frames.
    output logic serData = 1'b0, // Serial data.
    output logic loadStrobe = 1'b0 // Load strobe.
);
    timeunit 1ns;
    timeprecision 1ns;
    // Whole words only, bit 23 first; idle data is inverted so nothing stale lingers.
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(negedge mclk) serData = w[i];
            serClk = 1'b0;
            @(negedge mclk) serClk = 1'b1;
        end
        @(negedge mclk) serClk = 1'b0;
        serData = ~w[0];
        loadStrobe = 1'b1;
        @(negedge mclk) loadStrobe = 1'b0;
        @(negedge mclk);
    endtask
endmodule

// file: verification/scfg_latches_test.sv
// Self-checking bench for the synthesizer config block.
module scfg_latches_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] REFW = 24'h2ABCD5, CTLW = 24'h8ABCD0, FBW = 24'hC12346;
    logic mclk = 1'b0, sys_rst = 1'b1, chipEnable = 1'b1, refDivOut = 1'b0;
    logic serClk, serData, loadStrobe;
    logic [1:0] prescalerSelect, outputPowerLevel, coreCurrent, bandClockDivider, backlashWidth;
    logic [2:0] pumpCurrentTwo, pumpCurrentOne, outputMuxSelect;
    logic muteUntilLock, pumpGainSelect, pumpThreeState, detectorPolarity, dividerReset;
    logic halvedPrescalerInput, outputHalvingEnable, testEnableBit, lockPrecision, biasOn;
    logic powerDown, lockDetectClear, outputsHighZ, refBufferOff, bandSelectStart;
    logic [12:0] mainCount;
    logic [4:0] swallowCount;
    logic [13:0] refDivide;
    int errors = 0, checks = 0;
    scfg_latches u_scfg_latches (.*);
    scfg_host u_scfg_host (.*);
    always #50 mclk = ~mclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pulse;
        @(negedge mclk) refDivOut = 1'b1;
        @(negedge mclk) refDivOut = 1'b0;
        @(negedge mclk);
    endtask
    task automatic t_sequence;
        chk(biasOn, 1'b0);
        u_scfg_host.send(REFW);
        u_scfg_host.send(CTLW);
        chk(biasOn, 1'b1);
        chk({prescalerSelect, pumpCurrentTwo, pumpCurrentOne, outputPowerLevel, muteUntilLock,
            pumpGainSelect, pumpThreeState, detectorPolarity, outputMuxSelect, dividerReset,
            coreCurrent}, {CTLW[23:22], CTLW[19:2]});
        repeat (6000) @(negedge mclk);
        u_scfg_host.send(FBW);
        chk({halvedPrescalerInput, outputHalvingEnable, pumpGainSelect, mainCount, swallowCount},
            {FBW[23:8], FBW[6:2]});
        chk({bandClockDivider, testEnableBit, lockPrecision, backlashWidth, refDivide},
            REFW[21:2]);
    endtask
    task automatic t_async;
        u_scfg_host.send(CTLW | 24'h100000);
        chk({powerDown, outputsHighZ, lockDetectClear, refBufferOff, dividerReset,
            pumpThreeState}, 6'h3F);
        u_scfg_host.send(24'h000401);
        chk(refDivide, 14'h0100);
        u_scfg_host.send(CTLW);
        chk({powerDown, mainCount}, {1'b0, FBW[20:8]});
    endtask
    task automatic t_sync;
        u_scfg_host.send(CTLW | 24'h300000);
        pulse();
        chk(powerDown, 1'b0);
        pulse();
        chk(powerDown, 1'b1);
        u_scfg_host.send(CTLW);
    endtask
    task automatic t_ce;
        chipEnable = 1'b0;
        #1 chk(powerDown, 1'b1);
        @(negedge mclk) chipEnable = 1'b1;
        #1 chk(powerDown, 1'b0);
    endtask
    task automatic t_test;
        u_scfg_host.send(24'hFFFFFF);
        chk({mainCount, refDivide, pumpGainSelect}, {FBW[20:8], 14'h0100, 1'b1});
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge mclk);
        sys_rst = 1'b0;
        t_sequence();
        t_async();
        t_sync();
        t_ce();
        t_test();
        tally_and_finish();
    end
    // The run needs about 0.7 ms, so this limit only trips on a hang.
    initial begin
        #2ms;
        errors++;
        tally_and_finish();
    end
endmodule
